// *** logic/hpd_host_port.sv ***
// Parallel host port slave: strobes, acknowledge and direct access packets
`default_nettype none
// How it works
// - Address-phase high at reset selects cycle-control mode
// - Cycle-control mode latches address on write trailing
// - Address phase counts only while a select active
// - Address-phase level captured into config sense bit
// - Write data sampled trailing; read driven after leading
// - Strobe polarity from inactive levels at reset
// - Acknowledge polarity taken from strap, read-only
// - Acknowledge idles active in ack mode 01, inactive in others
// - Read needs data, no write; write needs room
// - Ack mode bits 7:6 strap-initialised, then writable
// - Mode 00 acknowledges, removes after strobe release
// - Mode 01 ready inserts waits; 10, 11 reserved
// - Address cycles always acknowledged at once
// - Bursts of 2-4 bytes or 1-2 words
// - Later address cycles ignored unless packet start
// - Strobes without address step the unit index
// - Acks wait for data and earlier writes
// - Read mode bits 5:4 choose request point
// - Read triggers only direct reads; 11 reserved
// - Address-phase low at reset: latch on falling
// - Releasing the select ends the ongoing access
module hpd_host_port
  import hpd_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              addrPhasePin,
  input  wire logic              readStrobePin,
  input  wire logic              writeStrobePin,
  input  wire logic              memorySpaceSelectN,
  input  wire logic              ioSpaceSelectN,
  input  wire logic              upperAddrLine,
  input  wire logic              ackPolarityStrap,
  input  wire logic [BUS_W-1:0]  muxedAddrDataBusIn,
  output logic      [BUS_W-1:0]  muxedAddrDataBusOut,
  output logic                   muxedAddrDataBusOe,
  input  wire logic              hostAckPinIn,
  output logic                   hostAckPinOut,
  output logic                   hostAckPinOe,
  input  wire logic              busWide16,
  input  wire logic              dataType24,
  input  wire logic              fourBytePacket,
  input  wire logic              orderMsbFirst,
  input  wire logic              cfgWrite,
  input  wire logic [CFG_W-1:0]  cfgWrData,
  output logic      [CFG_W-1:0]  hostPortConfig,
  output logic                   wrValid,
  input  wire logic              wrReady,
  output logic      [ADDR_W-1:0] wrAddr,
  output logic                   wrIsIo,
  output logic      [WORD_W-1:0] wrData,
  output logic                   rdReq,
  output logic      [ADDR_W-1:0] rdAddr,
  output logic                   rdIsIo,
  input  wire logic              rdRespValid,
  input  wire logic [WORD_W-1:0] rdRespData
);
  // Seven control pins, the upper address line, then the bus
  localparam int unsigned SYNC_W = 8 + BUS_W;
  localparam int unsigned BUFD_W = 1 + ADDR_W + WORD_W;

  logic [SYNC_W-1:0] pinSync;
  logic aleS, rdS, wrS, memSelS, ioSelS, ackS, polS, upS;
  logic [BUS_W-1:0] busS;

  hpd_sync #(.WIDTH(SYNC_W)) uPinSync (
    .mclk    (mclk),
    .rst     (rst),
    .asyncIn ({addrPhasePin, readStrobePin, writeStrobePin, memorySpaceSelectN,
               ioSpaceSelectN, hostAckPinIn, ackPolarityStrap, upperAddrLine,
               muxedAddrDataBusIn}),
    .syncOut (pinSync)
  );
  assign {aleS, rdS, wrS, memSelS, ioSelS, ackS, polS} = pinSync[SYNC_W-1:BUS_W+1];
  assign upS  = pinSync[BUS_W];
  assign busS = pinSync[BUS_W-1:0];

  // Strap capture group
  logic [3:0] holdCnt_q, holdCnt_d;
  logic       aleSense_q, aleSense_d, ackPol_q, ackPol_d;
  logic       rdIdle_q, rdIdle_d, wrIdle_q, wrIdle_d;
  logic [1:0] ackMode_q, ackMode_d, rdMode_q, rdMode_d;
  logic       senseWin;

  assign senseWin = holdCnt_q != STRAP_HOLD_LAST;

  always_comb begin
    holdCnt_d  = senseWin ? holdCnt_q + 4'h1 : holdCnt_q;
    aleSense_d = aleSense_q;
    ackPol_d   = ackPol_q;
    rdIdle_d   = rdIdle_q;
    wrIdle_d   = wrIdle_q;
    ackMode_d  = ackMode_q;
    rdMode_d   = rdMode_q;
    if (senseWin) begin
      aleSense_d = aleS;
      ackPol_d   = polS;
      rdIdle_d   = rdS;
      wrIdle_d   = wrS;
      // Idle at active level means ready mode, else acknowledge mode
      ackMode_d  = {1'b0, ackS == polS};
    end else if (cfgWrite) begin
      ackMode_d = cfgWrData[CFG_ACKM_LO +: 2];
      rdMode_d  = cfgWrData[CFG_RDM_LO +: 2];
    end
  end

  // Held in reset so the window restarts at release
  always_ff @(posedge mclk) begin
    if (rst) begin
      holdCnt_q  <= 4'h0;
      aleSense_q <= 1'b0;
      ackPol_q   <= 1'b1;
      rdIdle_q   <= 1'b1;
      wrIdle_q   <= 1'b1;
      ackMode_q  <= ACKM_ACK;
      rdMode_q   <= RDM_NORMAL;
    end else begin
      holdCnt_q  <= holdCnt_d;
      aleSense_q <= aleSense_d;
      ackPol_q   <= ackPol_d;
      rdIdle_q   <= rdIdle_d;
      wrIdle_q   <= wrIdle_d;
      ackMode_q  <= ackMode_d;
      rdMode_q   <= rdMode_d;
    end
  end

  assign hostPortConfig = {ackMode_q, rdMode_q, wrIdle_q, rdIdle_q, ackPol_q, aleSense_q};

  // Decoded pin activity
  logic selAct, rdAct, wrAct, aleAct;
  logic selPrev_q, rdPrev_q, wrPrev_q, alePrev_q;
  assign selAct = (!memSelS || !ioSelS) && !senseWin;
  assign rdAct  = rdS != rdIdle_q;
  assign wrAct  = wrS != wrIdle_q;
  assign aleAct = aleSense_q ? !aleS : aleS;

  // Write buffer wires
  logic              bufInValid, bufInReady, bufOutValid;
  logic [BUFD_W-1:0] bufInData, bufOutData;

  // Transfer control group
  hpd_state_e        state_q, state_d;
  logic              isRead_q, isRead_d, isAddr_q, isAddr_d;
  logic              inProg_q, inProg_d, spaceIo_q, spaceIo_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [1:0]        idx_q, idx_d;
  logic [2:0]        cnt_q, cnt_d;
  logic [31:0]       asm_q, asm_d, rdBuf_q, rdBuf_d;
  logic              rdValid_q, rdValid_d, rdPend_q, rdPend_d, rdWant_q, rdWant_d;
  logic              rdReq_q, rdReq_d;
  logic [ADDR_W-1:0] rdAddr_q, rdAddr_d;
  logic              rdIsIo_q, rdIsIo_d;
  logic              ackOut_q, ackOut_d, ackOe_q, ackOe_d;
  logic [BUS_W-1:0]  busOut_q, busOut_d;
  logic              busOe_q, busOe_d;
  logic [2:0]        pktLen;
  logic [1:0]        newIdx;
  logic [4:0]        unitOfs;
  logic              ok, lastUnit, rdRise, wrRise, strobeFall, aleFall;

  always_comb begin
    if (busWide16) pktLen = dataType24 ? 3'h2 : 3'h1;
    else           pktLen = dataType24 ? (fourBytePacket ? 3'h4 : 3'h3) : 3'h2;
    newIdx     = busWide16 ? {1'b0, busS[1]} : busS[1:0];
    unitOfs    = busWide16 ? {idx_q[0], 4'h0} : {idx_q, 3'h0};
    lastUnit   = cnt_q == pktLen - 3'h1;
    rdRise     = rdAct && !rdPrev_q;
    wrRise     = wrAct && !wrPrev_q;
    strobeFall = isRead_q ? (!rdAct && rdPrev_q) : (!wrAct && wrPrev_q);
    aleFall    = !aleAct && alePrev_q && !aleSense_q;
    ok         = 1'b0;
    state_d    = state_q;
    isRead_d   = isRead_q;
    isAddr_d   = isAddr_q;
    inProg_d   = inProg_q;
    spaceIo_d  = spaceIo_q;
    addr_d     = addr_q;
    idx_d      = idx_q;
    cnt_d      = cnt_q;
    asm_d      = asm_q;
    rdBuf_d    = rdBuf_q;
    rdValid_d  = rdValid_q;
    rdPend_d   = rdPend_q;
    rdWant_d   = rdWant_q;
    rdReq_d    = 1'b0;
    rdAddr_d   = rdAddr_q;
    rdIsIo_d   = rdIsIo_q;
    bufInValid = 1'b0;
    busOe_d    = 1'b0;
    busOut_d   = busOut_q;
    if (!selAct) begin
      state_d  = ST_IDLE;
      inProg_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (rdRise || wrRise) begin
            isRead_d = rdRise && !wrRise;
            isAddr_d = aleSense_q && aleAct && wrRise;
            state_d  = ST_WAIT;
            // Normal mode fetches fresh data on the packet's first read
            if (rdRise && !wrRise && !(aleSense_q && aleAct) && rdMode_q != RDM_PIPELINE
                && rdMode_q != RDM_PREFETCH && (!inProg_q || cnt_q == 3'h0)) begin
              rdValid_d = 1'b0;
              rdWant_d  = !rdPend_q;
            end
          end
        end
        ST_WAIT: begin
          if (isAddr_q) ok = 1'b1;
          else if (isRead_q) ok = rdValid_q && !bufOutValid && !rdPend_q;
          else ok = bufInReady;
          if (!(isRead_q ? rdAct : wrAct)) state_d = ST_IDLE;
          else if (ok) state_d = ST_HELD;
          // Fallback so a read never starves when no fetch is queued
          if (isRead_q && !rdValid_q && !rdPend_q && !rdWant_q) rdWant_d = 1'b1;
        end
        ST_HELD: begin
          if (strobeFall) begin
            state_d = ST_IDLE;
            if (!isAddr_q) begin
              if (!isRead_q) begin
                asm_d = asm_q;
                if (busWide16) asm_d[unitOfs +: 16] = busS;
                else asm_d[unitOfs +: 8] = busS[7:0];
                bufInValid = lastUnit;
              end else if (lastUnit) begin
                rdValid_d = 1'b0;
                if (rdMode_q == RDM_PIPELINE) rdWant_d = !rdPend_q;
              end
              idx_d    = orderMsbFirst ? idx_q - 2'h1 : idx_q + 2'h1;
              cnt_d    = lastUnit ? 3'h0 : cnt_q + 3'h1;
              inProg_d = !lastUnit;
            end
          end
        end
        default: state_d = ST_IDLE;
      endcase
      // Address latch for either address-phase mode
      if ((state_q == ST_HELD && strobeFall && isAddr_q) || aleFall) begin
        if (!inProg_q || (orderMsbFirst ? newIdx == 2'(pktLen - 3'h1) : newIdx == 2'h0)) begin
          addr_d    = {upS, busS};
          idx_d     = newIdx;
          cnt_d     = 3'h0;
          inProg_d  = 1'b1;
          spaceIo_d = !ioSelS;
          if (rdMode_q == RDM_PREFETCH) begin
            rdValid_d = 1'b0;
            rdWant_d  = !rdPend_q;
          end
        end
      end
      if ((state_q == ST_WAIT && ok) || state_q == ST_HELD) begin
        busOe_d  = isRead_q && !isAddr_q && rdAct;
        busOut_d = busWide16 ? rdBuf_q[unitOfs +: 16] : {8'h00, rdBuf_q[unitOfs +: 8]};
      end
    end
    // Fetch waits for posted writes to drain
    if (rdWant_d && !rdPend_q && !bufOutValid) begin
      rdReq_d  = 1'b1;
      rdAddr_d = addr_d;
      rdIsIo_d = spaceIo_d;
      rdPend_d = 1'b1;
      rdWant_d = 1'b0;
    end
    if (rdRespValid) begin
      rdBuf_d   = {8'h00, rdRespData};
      rdValid_d = 1'b1;
      rdPend_d  = 1'b0;
    end
    // Pin acts as input while straps are sensed
    ackOe_d = !senseWin;
    if (state_d == ST_HELD) ackOut_d = ackPol_q;
    else if (state_d == ST_WAIT) ackOut_d = !ackPol_q;
    else ackOut_d = (ackMode_q == ACKM_READY) ? ackPol_q : !ackPol_q;
    if (senseWin) ackOut_d = ackS;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      selPrev_q <= 1'b0;
      rdPrev_q  <= 1'b0;
      wrPrev_q  <= 1'b0;
      alePrev_q <= 1'b0;
      isRead_q  <= 1'b0;
      isAddr_q  <= 1'b0;
      inProg_q  <= 1'b0;
      spaceIo_q <= 1'b0;
      addr_q    <= '0;
      idx_q     <= 2'h0;
      cnt_q     <= 3'h0;
      asm_q     <= 32'h0;
      rdBuf_q   <= 32'h0;
      rdValid_q <= 1'b0;
      rdPend_q  <= 1'b0;
      rdWant_q  <= 1'b0;
      rdReq_q   <= 1'b0;
      rdAddr_q  <= '0;
      rdIsIo_q  <= 1'b0;
      ackOut_q  <= 1'b0;
      ackOe_q   <= 1'b0;
      busOut_q  <= '0;
      busOe_q   <= 1'b0;
    end else begin
      state_q   <= state_d;
      selPrev_q <= selAct;
      rdPrev_q  <= rdAct;
      wrPrev_q  <= wrAct;
      alePrev_q <= aleAct;
      isRead_q  <= isRead_d;
      isAddr_q  <= isAddr_d;
      inProg_q  <= inProg_d;
      spaceIo_q <= spaceIo_d;
      addr_q    <= addr_d;
      idx_q     <= idx_d;
      cnt_q     <= cnt_d;
      asm_q     <= asm_d;
      rdBuf_q   <= rdBuf_d;
      rdValid_q <= rdValid_d;
      rdPend_q  <= rdPend_d;
      rdWant_q  <= rdWant_d;
      rdReq_q   <= rdReq_d;
      rdAddr_q  <= rdAddr_d;
      rdIsIo_q  <= rdIsIo_d;
      ackOut_q  <= ackOut_d;
      ackOe_q   <= ackOe_d;
      busOut_q  <= busOut_d;
      busOe_q   <= busOe_d;
    end
  end

  assign bufInData = {spaceIo_q, addr_q, asm_d[WORD_W-1:0]};

  hpd_buf #(.WIDTH(BUFD_W), .DEPTH(BUF_DEPTH)) uWrBuf (
    .mclk     (mclk),
    .rst      (rst),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .inData   (bufInData),
    .outValid (bufOutValid),
    .outReady (wrReady),
    .outData  (bufOutData)
  );

  assign {wrIsIo, wrAddr, wrData} = bufOutData;
  assign wrValid             = bufOutValid;
  assign rdReq               = rdReq_q;
  assign rdAddr              = rdAddr_q;
  assign rdIsIo              = rdIsIo_q;
  assign hostAckPinOut       = ackOut_q;
  assign hostAckPinOe        = ackOe_q;
  assign muxedAddrDataBusOut = busOut_q;
  assign muxedAddrDataBusOe  = busOe_q;
endmodule : hpd_host_port
`default_nettype wire

// *** logic/hpd_pkg.sv ***
// Shared constants and types for the host port direct access block
`default_nettype none
package hpd_pkg;
  localparam int unsigned BUS_W       = 16;
  localparam int unsigned ADDR_W      = 17;
  localparam int unsigned WORD_W      = 24;
  localparam int unsigned CFG_W       = 8;
  // Configuration field positions
  localparam int unsigned CFG_ALE_SENSE = 0;
  localparam int unsigned CFG_ACK_POL   = 1;
  localparam int unsigned CFG_RD_IDLE   = 2;
  localparam int unsigned CFG_WR_IDLE   = 3;
  localparam int unsigned CFG_RDM_LO    = 4;
  localparam int unsigned CFG_ACKM_LO   = 6;
  // Acknowledge modes
  localparam logic [1:0] ACKM_ACK   = 2'h0;
  localparam logic [1:0] ACKM_READY = 2'h1;
  // Read trigger modes
  localparam logic [1:0] RDM_NORMAL   = 2'h0;
  localparam logic [1:0] RDM_PIPELINE = 2'h1;
  localparam logic [1:0] RDM_PREFETCH = 2'h2;
  // Strap hold after reset release
  localparam int unsigned STRAP_HOLD_CYCLES = 10;
  localparam logic [3:0]  STRAP_HOLD_LAST   = 4'(STRAP_HOLD_CYCLES);
  localparam int unsigned BUF_DEPTH = 2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_HELD = 3'b100
  } hpd_state_e;
endpackage : hpd_pkg
`default_nettype wire

// *** logic/hpd_sync.sv ***
// Two-flop synchroniser for a vector of pin inputs
`default_nettype none
module hpd_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;
endmodule : hpd_sync
`default_nettype wire

// *** logic/hpd_buf.sv ***
// Small FIFO holding posted writes on their way inward
`default_nettype none
module hpd_buf #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [PW:0]      cnt_q, cnt_d;
  logic             inReady_q, inReady_d, outValid_q, outValid_d;
  logic             doPush, doPop;

  always_comb begin
    doPush     = inValid && inReady_q;
    doPop      = outValid_q && outReady;
    wrPtr_d    = doPush ? ((wrPtr_q == LAST_PTR) ? '0 : wrPtr_q + 1'b1) : wrPtr_q;
    rdPtr_d    = doPop ? ((rdPtr_q == LAST_PTR) ? '0 : rdPtr_q + 1'b1) : rdPtr_q;
    cnt_d      = cnt_q + (PW+1)'(doPush) - (PW+1)'(doPop);
    inReady_d  = cnt_d != FULL_CNT;
    outValid_d = cnt_d != '0;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr_q    <= '0;
      rdPtr_q    <= '0;
      cnt_q      <= '0;
      inReady_q  <= 1'b1;
      outValid_q <= 1'b0;
    end else begin
      wrPtr_q    <= wrPtr_d;
      rdPtr_q    <= rdPtr_d;
      cnt_q      <= cnt_d;
      inReady_q  <= inReady_d;
      outValid_q <= outValid_d;
    end
  end

  // Storage has no reset; valid guards it
  always_ff @(posedge mclk) begin
    if (doPush) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  assign inReady  = inReady_q;
  assign outValid = outValid_q;
  assign outData  = mem_q[rdPtr_q];
endmodule : hpd_buf
`default_nettype wire

// *** dv/hpd_host_port_asserts.sv ***
// Concurrent checks on the host port pins and internal handshakes
`default_nettype none
module hpd_host_port_asserts
  import hpd_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              readStrobePin,
  input wire logic              writeStrobePin,
  input wire logic              hostAckPinOut,
  input wire logic              hostAckPinOe,
  input wire logic              cfgWrite,
  input wire logic [CFG_W-1:0]  cfgWrData,
  input wire logic [CFG_W-1:0]  hostPortConfig,
  input wire logic              muxedAddrDataBusOe,
  input wire logic              wrValid,
  input wire logic              wrReady,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [WORD_W-1:0] wrData,
  input wire logic              rdReq,
  input wire logic [ADDR_W-1:0] rdAddr
);
  logic [3:0] cycQ;
  logic [3:0] cycD;
  logic       live;
  logic       rdAct;
  logic       wrAct;
  logic       ackAct;
  logic       idle;
  logic       m00;
  logic       m01;
  always_comb begin
    cycD = (cycQ == 4'hF) ? cycQ : cycQ + 4'h1;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      cycQ <= 4'h0;
    end else begin
      cycQ <= cycD;
    end
  end
  // Strap bits settle well before the counter saturates
  assign live   = cycQ == 4'hF;
  assign rdAct  = readStrobePin != hostPortConfig[CFG_RD_IDLE];
  assign wrAct  = writeStrobePin != hostPortConfig[CFG_WR_IDLE];
  assign ackAct = hostAckPinOut == hostPortConfig[CFG_ACK_POL];
  assign idle   = live && !rdAct && !wrAct;
  assign m00    = hostPortConfig[CFG_ACKM_LO+:2] == ACKM_ACK;
  assign m01    = hostPortConfig[CFG_ACKM_LO+:2] == ACKM_READY;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence sQuiet00;
    (idle && m00) [*5];
  endsequence
  sequence sQuiet01;
    (idle && m01) [*5];
  endsequence
  AST_ACK_OE_STRAP: assert property ($fell(rst) |-> !hostAckPinOe [*8])
    else $error("ack pin driven inside strap window");
  AST_CFG_RO: assert property (live |-> $stable(hostPortConfig[3:0]))
    else $error("sensed config bits changed");
  AST_CFG_WR: assert property (live && cfgWrite |=>
    hostPortConfig[7:4] == $past(cfgWrData[7:4])) else $error("config write lost");
  AST_RDREQ_NO_WR: assert property (rdReq |-> !wrValid)
    else $error("read request with write pending");
  AST_BUS_DRIVE: assert property ($rose(muxedAddrDataBusOe) |-> rdAct && ackAct)
    else $error("bus driven outside an acknowledged read");
  AST_ACK_CAUSE: assert property (live && m00 && $rose(ackAct) |->
    $past(rdAct || wrAct, 3)) else $error("acknowledge without strobe");
  AST_ACK_DROP: assert property (sQuiet00 |-> !ackAct)
    else $error("acknowledge left active after strobe release");
  AST_READY_IDLE: assert property (sQuiet01 |-> ackAct)
    else $error("ready line idle inactive");
  AST_WR_HOLD: assert property (wrValid && !wrReady |=>
    wrValid && $stable(wrData) && $stable(wrAddr)) else $error("stalled write changed");
  AST_RDADDR_HOLD: assert property (!rdReq |=> rdReq || $stable(rdAddr))
    else $error("read address moved without request");
endmodule // hpd_host_port_asserts
bind hpd_host_port hpd_host_port_asserts u_chk (.mclk(mclk), .rst(rst),
  .readStrobePin(readStrobePin), .writeStrobePin(writeStrobePin),
  .hostAckPinOut(hostAckPinOut), .hostAckPinOe(hostAckPinOe), .cfgWrite(cfgWrite),
  .cfgWrData(cfgWrData), .hostPortConfig(hostPortConfig),
  .muxedAddrDataBusOe(muxedAddrDataBusOe), .wrValid(wrValid), .wrReady(wrReady),
  .wrAddr(wrAddr), .wrData(wrData), .rdReq(rdReq), .rdAddr(rdAddr));
`default_nettype wire

// *** dv/hpd_host_model.sv ***
// Host processor model driving the parallel port pins
`default_nettype none
module hpd_host_model
  import hpd_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             ackWire,
  input  wire logic [BUS_W-1:0] busWire,
  output logic                  aph,
  output logic                  rdN,
  output logic                  wrN,
  output logic                  msN,
  output logic                  ioN,
  output logic      [BUS_W-1:0] busDrv
);
  timeunit 1ns;
  timeprecision 1ps;
  // Straps held through reset and the window after it
  initial begin
    aph = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
    msN = 1'b1;
    ioN = 1'b1;
    busDrv = 16'h0000;
  end
  task automatic sel(input logic m, input logic i);
    @(negedge mclk);
    msN = m;
    ioN = i;
  endtask
  task automatic acc(input logic isRd, input logic isAdr, input logic [BUS_W-1:0] wd,
                     output logic [BUS_W-1:0] rd);
    int n;
    @(negedge mclk);
    aph = !isAdr;
    busDrv = wd;
    if (isRd) rdN = 1'b0;
    else wrN = 1'b0;
    n = 0;
    // Ready line is stale until the port has seen the strobe
    repeat (5) @(posedge mclk);
    while (ackWire !== 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    rd = busWire;
    if (n >= 400) begin
      $display("unexpected ack expected 1 seen %b", ackWire);
      hpd_host_port_tb.failures++;
      hpd_host_port_tb.print_verdict();
    end
    @(negedge mclk);
    rdN = 1'b1;
    wrN = 1'b1;
    repeat (4) @(negedge mclk);
    aph = 1'b1;
    // Released bus shows no stale value
    busDrv = ~busDrv;
  endtask
endmodule // hpd_host_model
`default_nettype wire

// *** dv/hpd_host_port_tb.sv ***
// Self-checking bench for the host port direct access block
`default_nettype none
module hpd_host_port_tb
  import hpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk, rst, up, cfgWrite, wrReady, rdRespValid;
  logic [CFG_W-1:0]  cfgWrData;
  logic [WORD_W-1:0] rdRespData, wrData;
  logic              aph, rdN, wrN, msN, ioN, busOe, ackOut, ackOe, ackWire;
  logic              wrValid, wrIsIo, rdReq;
  logic [BUS_W-1:0]  busDrv, busOut, busWire, rd, lo;
  logic [ADDR_W-1:0] wrAddr, rdAddr, ra;
  logic [CFG_W-1:0]  cfg;
  logic [33:0]       expq[$];
  int                failures, tests_run, nReq, rcnt, n0;
  int                rm[4] = '{0, 2, 3, 1};
  assign ackWire = ackOe ? ackOut : 1'b0;
  assign busWire = busOe ? busOut : busDrv;
  hpd_host_port DUT (.mclk(mclk), .rst(rst), .addrPhasePin(aph), .readStrobePin(rdN),
    .writeStrobePin(wrN), .memorySpaceSelectN(msN), .ioSpaceSelectN(ioN),
    .upperAddrLine(up), .ackPolarityStrap(1'b1), .muxedAddrDataBusIn(busWire),
    .muxedAddrDataBusOut(busOut), .muxedAddrDataBusOe(busOe), .hostAckPinIn(ackWire),
    .hostAckPinOut(ackOut), .hostAckPinOe(ackOe), .busWide16(1'b0), .dataType24(1'b0),
    .fourBytePacket(1'b0), .orderMsbFirst(1'b0), .cfgWrite(cfgWrite),
    .cfgWrData(cfgWrData), .hostPortConfig(cfg), .wrValid(wrValid), .wrReady(wrReady),
    .wrAddr(wrAddr), .wrIsIo(wrIsIo), .wrData(wrData), .rdReq(rdReq), .rdAddr(rdAddr),
    .rdIsIo(), .rdRespValid(rdRespValid), .rdRespData(rdRespData));
  hpd_host_model host (.mclk(mclk), .ackWire(ackWire), .busWire(busWire), .aph(aph),
    .rdN(rdN), .wrN(wrN), .msN(msN), .ioN(ioN), .busDrv(busDrv));
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cfgw(input logic [CFG_W-1:0] d);
    @(negedge mclk);
    cfgWrite = 1'b1;
    cfgWrData = d;
    @(negedge mclk);
    cfgWrite = 1'b0;
    @(negedge mclk);
  endtask
  task automatic wpkt(input logic [15:0] a, input logic [15:0] d, input logic io);
    expq.push_back({io, up, a, d});
    host.acc(1'b0, 1'b1, a, rd);
    host.acc(1'b0, 1'b0, {8'h00, d[7:0]}, rd);
    host.acc(1'b0, 1'b0, {8'h00, d[15:8]}, rd);
  endtask
  task automatic rpkt(input logic [15:0] a, input int m);
    n0 = nReq;
    host.acc(1'b0, 1'b1, a, rd);
    repeat (4) @(posedge mclk);
    chk("prefetch request", 34'(m == 2), 34'(nReq != n0));
    host.acc(1'b1, 1'b0, 16'h0000, lo);
    host.acc(1'b1, 1'b0, 16'h0000, rd);
    chk("read word", 34'(a ^ 16'hA55A), {rd[7:0], lo[7:0]});
    chk("read address", {1'b0, a}, ra);
  endtask
  // Internal side: posted write sink and read responder
  always @(posedge mclk) begin
    if (wrValid === 1'b1 && wrReady === 1'b1) begin
      if (expq.size() == 0) chk("stray write", 34'h0, 34'h1);
      else chk("write word", expq.pop_front(), {wrIsIo, wrAddr, wrData[15:0]});
    end
    if (rdReq === 1'b1) begin
      nReq++;
      ra = rdAddr;
      rcnt = 3;
    end
  end
  always @(negedge mclk) begin
    rdRespValid = 1'b0;
    if (rcnt == 1) begin
      rdRespValid = 1'b1;
      rdRespData = {8'hC3, ra[15:0] ^ 16'hA55A};
    end
    if (rcnt > 0) rcnt--;
  end
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1;
    up = 1'b0;
    cfgWrite = 1'b0;
    cfgWrData = 8'h00;
    wrReady = 1'b1;
    rdRespValid = 1'b0;
    rdRespData = 24'h000000;
    repeat (20) @(negedge mclk);
    chk("reset config", 8'h0E, cfg);
    chk("reset ack enable", 1'b0, ackOe);
    rst = 1'b0;
    repeat (20) @(negedge mclk);
    chk("sensed config", 8'h0F, cfg);
    chk("ack enable", 1'b1, ackOe);
    chk("ack idle", 1'b0, ackWire);
    host.sel(1'b0, 1'b1);
    wpkt(16'h0010, 16'h1234, 1'b0);
    up = 1'b1;
    wpkt(16'h0020, 16'h5678, 1'b0);
    up = 1'b0;
    // Mid-packet address that is not a packet start
    expq.push_back({2'b00, 16'h0030, 16'h2211});
    host.acc(1'b0, 1'b1, 16'h0030, rd);
    host.acc(1'b0, 1'b0, 16'h0011, rd);
    host.acc(1'b0, 1'b1, 16'h0031, rd);
    host.acc(1'b0, 1'b0, 16'h0022, rd);
    // Select release drops the half-built word
    host.sel(1'b1, 1'b0);
    host.acc(1'b0, 1'b1, 16'h0040, rd);
    host.acc(1'b0, 1'b0, 16'h00AA, rd);
    host.sel(1'b1, 1'b1);
    host.sel(1'b1, 1'b0);
    wpkt(16'h0044, 16'hBEEF, 1'b1);
    host.sel(1'b1, 1'b1);
    host.sel(1'b0, 1'b1);
    wrReady = 1'b0;
    wpkt(16'h0050, 16'h0A0B, 1'b0);
    wpkt(16'h0054, 16'h0C0D, 1'b0);
    fork
      wpkt(16'h0058, 16'h0E0F, 1'b0);
      begin
        repeat (60) @(negedge mclk);
        chk("write refused", 1'b0, wrN);
        wrReady = 1'b1;
      end
    join
    cfgw(8'h40);
    repeat (8) @(negedge mclk);
    chk("ready idle", 1'b1, ackWire);
    wpkt(16'h0060, 16'h7788, 1'b0);
    for (int i = 0; i < 4; i++) begin
      cfgw(8'(rm[i] << 4));
      chk("read mode", 8'(rm[i] << 4) | 8'h0F, cfg);
      rpkt(16'h0080 + 16'(4 * i), rm[i]);
    end
    chk("writes left", 34'h0, 34'(expq.size()));
    print_verdict();
  end
endmodule // hpd_host_port_tb
`default_nettype wire
